// >>> dpcs_clock_select.sv
// Dual-loop core clock source select with its configuration register.
// Assumes loop analog and clock mux sit outside; pins are asynchronous.
`include "dpcs_defs.svh"
`default_nettype none

module dpcs_clock_select #(
    parameter int unsigned LOCK_NS = `DPCS_LOCK_NS_DEFAULT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Pins
    input wire logic hardResetInN,
    input wire logic [4:0] extCfgPins,
    input wire logic [1:0] extRangePins,
    // Register port
    input wire dpcs_pkg::dpcs_req_s busReq,
    output var logic [`DPCS_DATA_W-1:0] rdataQ,
    // Loop control
    output var dpcs_pkg::dpcs_loop_s loopZeroCfgQ,
    output var dpcs_pkg::dpcs_loop_s loopOneCfgQ,
    output var logic loopZeroPowerQ,
    output var logic loopOnePowerQ,
    // Core clock mux
    output var logic clkSelOne,
    output var logic clkGateEn,
    output var logic sourceInUse,
    output var logic changeBusy,
    // Core reset
    output var logic coreResetQ
);

    // Rounded up: a lock time that is not a whole number of bus cycles
    // must still be waited out in full
    localparam int unsigned LOCK_CYCLES =
        (LOCK_NS + `DPCS_CLK_PERIOD_NS - 1) / `DPCS_CLK_PERIOD_NS;

    // A lock time below one bus cycle cannot be counted
    if (LOCK_NS < `DPCS_CLK_PERIOD_NS)
    begin
        $error("LOCK_NS must cover at least one clock period");
    end

    // Codes that stop a loop instead of multiplying
    function automatic logic multIsOff(input logic [4:0] m);
        multIsOff = (m == `DPCS_MULT_OFF_A) || (m == `DPCS_MULT_OFF_B)
            || (m == `DPCS_MULT_OFF_C);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Hard reset and strap pins are asynchronous: two flops each before
    // any logic looks at them. The hard reset pair starts asserted, so
    // nothing runs a cycle on unsynchronised pins after power-on.
    logic hrstMeta;
    logic hrstSyncN;
    logic [6:0] pinMeta;
    logic [6:0] pinSync;
    logic hardRst;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hrstMeta <= 1'b0;
            hrstSyncN <= 1'b0;
        end
        else
        begin
            hrstMeta <= hardResetInN;
            hrstSyncN <= hrstMeta;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else
        begin
            pinMeta <= {extRangePins, extCfgPins};
            pinSync <= pinMeta;
        end
    end

    assign hardRst = !hrstSyncN;

    ////////////////////////////////////////////////////////////////////
    // Strap capture

    // Pins are only trusted while hard reset is held; once released the
    // captured value stands, so pin noise cannot retune a running loop.
    dpcs_pkg::dpcs_loop_s strapQ;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            strapQ <= '0;
        else if (hardRst)
            strapQ <= {pinSync[4:0], pinSync[6:5]};
    end

    ////////////////////////////////////////////////////////////////////
    // Clock configuration register

    logic psQ;
    logic pi0Q;
    logic [4:0] pc0Q;
    logic [1:0] pr0Q;
    logic [4:0] pc1Q;
    logic [1:0] pr1Q;
    logic cfgWr;
    logic statRd;
    logic cfgRd;
    logic [`DPCS_DATA_W-1:0] wd;

    assign wd = busReq.wdata;

    // Unmapped offsets decode to nothing: writes vanish, reads give zero
    always_comb
    begin
        cfgWr = 1'b0;
        cfgRd = 1'b0;
        statRd = 1'b0;
        if (busReq.addr == `DPCS_OFF_CFG)
        begin
            cfgWr = busReq.wr;
            cfgRd = busReq.rd;
        end
        else if (busReq.addr == `DPCS_OFF_STAT)
        begin
            statRd = busReq.rd;
        end
    end

    // Read-only fields and bits 24 to 31 simply have no storage.
    // Hard reset returns every writable field to zero, which means
    // loop zero from pins, loop one off in its medium range
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            psQ <= 1'b0;
            pi0Q <= 1'b0;
            pc0Q <= `DPCS_MULT_RST;
            pr0Q <= `DPCS_RNG_RST;
            pc1Q <= `DPCS_MULT_RST;
            pr1Q <= `DPCS_RNG_RST;
        end
        else if (hardRst)
        begin
            psQ <= 1'b0;
            pi0Q <= 1'b0;
            pc0Q <= `DPCS_MULT_RST;
            pr0Q <= `DPCS_RNG_RST;
            pc1Q <= `DPCS_MULT_RST;
            pr1Q <= `DPCS_RNG_RST;
        end
        else if (cfgWr)
        begin
            psQ <= wd[`DPCS_PS_BIT];
            pi0Q <= wd[`DPCS_PI0_BIT];
            pc0Q <= wd[`DPCS_PC0_HI:`DPCS_PC0_LO];
            pr0Q <= wd[`DPCS_PR0_HI:`DPCS_PR0_LO];
            pc1Q <= wd[`DPCS_PC1_HI:`DPCS_PC1_LO];
            pr1Q <= wd[`DPCS_PR1_HI:`DPCS_PR1_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Effective loop settings

    dpcs_pkg::dpcs_loop_s loopZeroEff;
    dpcs_pkg::dpcs_loop_s loopOneEff;
    logic loopZeroOn;
    logic loopOneOn;

    // Loop zero follows the strap until software takes internal control
    always_comb
    begin
        if (pi0Q)
            loopZeroEff = {pc0Q, pr0Q};
        else
            loopZeroEff = strapQ;
        loopOneEff = {pc1Q, pr1Q};
    end

    // Internal control with a zero multiplier stops loop zero
    assign loopZeroOn = !multIsOff(loopZeroEff.mult);
    assign loopOneOn = !multIsOff(loopOneEff.mult);

    // Registered so the loop side sees one clean change per edge
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            loopZeroCfgQ <= '0;
            loopOneCfgQ <= '0;
            loopZeroPowerQ <= 1'b0;
            loopOnePowerQ <= 1'b0;
        end
        else
        begin
            loopZeroCfgQ <= loopZeroEff;
            loopOneCfgQ <= loopOneEff;
            loopZeroPowerQ <= loopZeroOn;
            loopOnePowerQ <= loopOneOn;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lock tracking

    logic restartZero;
    logic restartOne;
    logic lockZero;
    logic lockOne;

    // The timers stand in for lock detect; the analog loops sit outside.
    // Any change of a loop's setting starts its lock time again
    assign restartZero = hardRst || (loopZeroEff != loopZeroCfgQ);
    assign restartOne = hardRst || (loopOneEff != loopOneCfgQ);

    // One timer design and one lock count serve both loops
    dpcs_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock_zero (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .restart(restartZero),
        .powered(loopZeroOn),
        .locked(lockZero)
    );

    dpcs_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock_one (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .restart(restartOne),
        .powered(loopOneOn),
        .locked(lockOne)
    );

    ////////////////////////////////////////////////////////////////////
    // Core reset

    // Core stays in reset through hard reset and until loop zero locks
    // again; after release a later loop zero stop does not re-enter it.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            coreResetQ <= 1'b1;
        else if (hardRst)
            coreResetQ <= 1'b1;
        else if (lockZero)
            coreResetQ <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Changeover

    // No lock check here: selecting an unlocked or stopped loop is a
    // software fault, and the sequencer must still finish in time.
    dpcs_clk_switch u_switch (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .syncClr(hardRst),
        .reqSel(psQ),
        .muxSel(clkSelOne),
        .gateEn(clkGateEn),
        .inUse(sourceInUse),
        .busy(changeBusy)
    );

    ////////////////////////////////////////////////////////////////////
    // Read path

    function automatic logic [`DPCS_DATA_W-1:0] cfgWord();
        logic [`DPCS_DATA_W-1:0] w;
        w = `DPCS_WORD_ZERO;
        w[`DPCS_EXTCFG_HI:`DPCS_EXTCFG_LO] = strapQ.mult;
        w[`DPCS_EXTRNG_HI:`DPCS_EXTRNG_LO] = strapQ.range;
        w[`DPCS_PS_BIT] = psQ;
        w[`DPCS_PSS_BIT] = sourceInUse;
        w[`DPCS_PI0_BIT] = pi0Q;
        w[`DPCS_PC0_HI:`DPCS_PC0_LO] = pc0Q;
        w[`DPCS_PR0_HI:`DPCS_PR0_LO] = pr0Q;
        w[`DPCS_PC1_HI:`DPCS_PC1_LO] = pc1Q;
        w[`DPCS_PR1_HI:`DPCS_PR1_LO] = pr1Q;
        cfgWord = w;
    endfunction

    function automatic logic [`DPCS_DATA_W-1:0] statWord();
        logic [`DPCS_DATA_W-1:0] w;
        w = `DPCS_WORD_ZERO;
        w[`DPCS_ST_LOCK0_BIT] = lockZero;
        w[`DPCS_ST_LOCK1_BIT] = lockOne;
        // Busy also covers the cycle between a select write and the
        // sequencer's first edge, so a poll right after the write
        // never misses a changeover that has not begun yet
        w[`DPCS_ST_BUSY_BIT] = changeBusy || (psQ != sourceInUse);
        w[`DPCS_ST_CORERST_BIT] = coreResetQ;
        statWord = w;
    endfunction

    // Data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdataQ <= `DPCS_WORD_ZERO;
        else if (cfgRd)
            rdataQ <= cfgWord();
        else if (statRd)
            rdataQ <= statWord();
        else
            rdataQ <= `DPCS_WORD_ZERO;
    end

endmodule

`default_nettype wire

// >>> dpcs_defs.svh
// Constants for the dual-loop clock select block: register offsets,
// field positions, reset values and timing.
// Assumes inclusion by bare name from every design file of the block.
`ifndef DPCS_DEFS_SVH
`define DPCS_DEFS_SVH

// Register port
`define DPCS_ADDR_W 4
`define DPCS_DATA_W 32
`define DPCS_OFF_CFG 4'h0
`define DPCS_OFF_STAT 4'h4

// Clock configuration register fields
`define DPCS_EXTCFG_HI 4
`define DPCS_EXTCFG_LO 0
`define DPCS_EXTRNG_HI 6
`define DPCS_EXTRNG_LO 5
`define DPCS_PS_BIT 7
`define DPCS_PSS_BIT 8
`define DPCS_PI0_BIT 9
`define DPCS_PC0_HI 14
`define DPCS_PC0_LO 10
`define DPCS_PR0_HI 16
`define DPCS_PR0_LO 15
`define DPCS_PC1_HI 21
`define DPCS_PC1_LO 17
`define DPCS_PR1_HI 23
`define DPCS_PR1_LO 22

// Status register fields
`define DPCS_ST_LOCK0_BIT 0
`define DPCS_ST_LOCK1_BIT 1
`define DPCS_ST_BUSY_BIT 2
`define DPCS_ST_CORERST_BIT 3

// Reset values
`define DPCS_MULT_RST 5'h00
`define DPCS_RNG_RST 2'h0
`define DPCS_WORD_ZERO 32'h0000_0000

// Multiplier codes that stop the loop
`define DPCS_MULT_OFF_A 5'h00
`define DPCS_MULT_OFF_B 5'h01
`define DPCS_MULT_OFF_C 5'h1f

// Timing
`define DPCS_CLK_PERIOD_NS 20
`define DPCS_LOCK_NS_DEFAULT 100000

`endif

// >>> dpcs_pkg.sv
// Types shared by the dual-loop clock select block.
// Assumes dpcs_defs.svh is reachable on the include path.
`include "dpcs_defs.svh"
`default_nettype none

package dpcs_pkg;

    // Multiplier and range of one loop
    typedef struct packed {
        logic [4:0] mult;
        logic [1:0] range;
    } dpcs_loop_s;

    // One register port request
    typedef struct packed {
        logic [`DPCS_ADDR_W-1:0] addr;
        logic [`DPCS_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dpcs_req_s;

    // Changeover sequencer states
    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_QUIET = 3'b010,
        SW_SWAP = 3'b100
    } dpcs_sw_e;

endpackage

`default_nettype wire

// >>> dpcs_lock_timer.sv
// Lock timer for one loop: counts a fixed settle time after every
// restart while the loop is powered.
// Assumes restart and powered come from logic on sys_clk.
`include "dpcs_defs.svh"
`default_nettype none

module dpcs_lock_timer #(
    parameter int unsigned LOCK_CYCLES = 5000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control
    input wire logic restart,
    input wire logic powered,
    // Status
    output var logic locked
);

    localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);
    localparam logic [CW-1:0] LIM = CW'(LOCK_CYCLES);

    // A zero count would report lock on a loop that never settled
    if (LOCK_CYCLES < 1)
    begin
        $error("LOCK_CYCLES must be at least one");
    end

    logic [CW-1:0] cntQ;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cntQ <= '0;
        else if (restart || !powered)
            cntQ <= '0;
        else if (cntQ != LIM)
            cntQ <= cntQ + CW'(1);
    end

    // A stopped or just-changed loop is never reported locked
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            locked <= 1'b0;
        else if (restart || !powered)
            locked <= 1'b0;
        else if (cntQ == LIM)
            locked <= 1'b1;
    end

endmodule

`default_nettype wire

// >>> dpcs_clk_switch.sv
// Changeover sequencer: gates the core clock off, swaps the mux,
// gates it on again and reports the loop in use on that same edge.
// Assumes reqSel and syncClr come from logic on sys_clk.
`include "dpcs_defs.svh"
`default_nettype none

module dpcs_clk_switch (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic syncClr,
    // Request
    input wire logic reqSel,
    // Clock mux control and status
    output var logic muxSel,
    output var logic gateEn,
    output var logic inUse,
    output var logic busy
);

    dpcs_pkg::dpcs_sw_e stateQ;
    dpcs_pkg::dpcs_sw_e stateD;
    logic targetQ;
    logic start;

    assign start = (stateQ == dpcs_pkg::SW_IDLE) && (reqSel != inUse);

    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            dpcs_pkg::SW_IDLE: if (start) stateD = dpcs_pkg::SW_QUIET;
            dpcs_pkg::SW_QUIET: stateD = dpcs_pkg::SW_SWAP;
            dpcs_pkg::SW_SWAP: stateD = dpcs_pkg::SW_IDLE;
            default: stateD = dpcs_pkg::SW_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            stateQ <= dpcs_pkg::SW_IDLE;
        else if (syncClr)
            stateQ <= dpcs_pkg::SW_IDLE;
        else
            stateQ <= stateD;
    end

    // Target is latched so a rewrite mid-swap cannot tear the mux
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            targetQ <= 1'b0;
        else if (start)
            targetQ <= reqSel;
    end

    // Gate is low across the mux swap so no runt pulse escapes
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            gateEn <= 1'b1;
        else if (syncClr)
            gateEn <= 1'b1;
        else if (start)
            gateEn <= 1'b0;
        else if (stateQ == dpcs_pkg::SW_SWAP)
            gateEn <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            muxSel <= 1'b0;
        else if (syncClr)
            muxSel <= 1'b0;
        else if (stateQ == dpcs_pkg::SW_QUIET)
            muxSel <= targetQ;
    end

    // In-use follows only once the gate reopens
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            inUse <= 1'b0;
        else if (syncClr)
            inUse <= 1'b0;
        else if (stateQ == dpcs_pkg::SW_SWAP)
            inUse <= muxSel;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            busy <= 1'b0;
        else if (syncClr)
            busy <= 1'b0;
        else
            busy <= (stateD != dpcs_pkg::SW_IDLE);
    end

endmodule

`default_nettype wire

// >>> dpcs_clock_select_chk.sv
// Checker for the dual-loop clock select block, bound to its top.
// Assumes one clock domain; sees only the top module's ports.
`include "dpcs_defs.svh"
`default_nettype none

module dpcs_clock_select_chk #(
    parameter int unsigned LOCK_NS = `DPCS_LOCK_NS_DEFAULT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Pins
    input wire logic hardResetInN,
    input wire logic [4:0] extCfgPins,
    input wire logic [1:0] extRangePins,
    // Register port
    input wire dpcs_pkg::dpcs_req_s busReq,
    input wire logic [`DPCS_DATA_W-1:0] rdataQ,
    // Loop control
    input wire dpcs_pkg::dpcs_loop_s loopZeroCfgQ,
    input wire dpcs_pkg::dpcs_loop_s loopOneCfgQ,
    input wire logic loopZeroPowerQ,
    input wire logic loopOnePowerQ,
    // Core clock mux and reset
    input wire logic clkSelOne,
    input wire logic clkGateEn,
    input wire logic sourceInUse,
    input wire logic changeBusy,
    input wire logic coreResetQ
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Changeover
    a_change_three: assert property ($rose(changeBusy) |-> !clkGateEn
        ##1 (!clkGateEn && changeBusy)
        ##1 (clkGateEn && !changeBusy && sourceInUse == clkSelOne))
        else $error("changeover did not finish in three cycles");
    a_inuse_settled: assert property ($fell(changeBusy)
        |-> sourceInUse == clkSelOne)
        else $error("in-use bit disagrees with mux after changeover");
    a_inuse_hold: assert property (changeBusy
        |-> $stable(sourceInUse))
        else $error("in-use bit moved during changeover");
    // Outside core reset the mux may only move behind a closed gate, or runt pulses escape
    a_mux_gated: assert property ($changed(clkSelOne) && !coreResetQ
        |-> !clkGateEn)
        else $error("mux changed with clock gate open");
    a_write_starts: assert property (busReq.wr
        && busReq.addr == `DPCS_OFF_CFG
        && busReq.wdata[`DPCS_PS_BIT] != sourceInUse
        && !changeBusy && !$past(changeBusy) && !coreResetQ
        && hardResetInN && $past(hardResetInN) && $past(hardResetInN, 2)
        |=> ##1 (changeBusy && !clkGateEn))
        else $error("select write did not start a changeover");

    ////////////////////////////////////////////////////////////////////////
    // Hard reset and loop settings
    a_hard_core: assert property (!hardResetInN [*4] |=> coreResetQ)
        else $error("core not held in reset by hard reset");
    a_hard_loop_zero: assert property (!hardResetInN [*8]
        |-> !clkSelOne && !sourceInUse && !changeBusy)
        else $error("hard reset did not return to loop zero");
    a_one_hard_off: assert property (!hardResetInN [*5]
        |=> loopOneCfgQ == 7'h00 && !loopOnePowerQ)
        else $error("loop one not off after hard reset");
    a_zero_strap: assert property ((!hardResetInN && $stable(extCfgPins)
        && $stable(extRangePins)) [*6]
        |-> loopZeroCfgQ == {extCfgPins, extRangePins})
        else $error("loop zero not following the pins");
    a_core_release: assert property ($fell(coreResetQ)
        |-> hardResetInN && loopZeroPowerQ)
        else $error("core released without running loop zero");
    a_zero_off_power: assert property ((loopZeroCfgQ.mult == 5'h00) [*2]
        |-> !loopZeroPowerQ)
        else $error("loop zero powered with off multiplier");

    c_to_one: cover property ($rose(sourceInUse));
    c_to_zero: cover property ($fell(sourceInUse));
    c_hard: cover property (!hardResetInN [*8] ##1 hardResetInN);
endmodule

`default_nettype wire

bind dpcs_clock_select dpcs_clock_select_chk #(.LOCK_NS(LOCK_NS)) u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .hardResetInN(hardResetInN),
    .extCfgPins(extCfgPins), .extRangePins(extRangePins),
    .busReq(busReq), .rdataQ(rdataQ), .loopZeroCfgQ(loopZeroCfgQ),
    .loopOneCfgQ(loopOneCfgQ), .loopZeroPowerQ(loopZeroPowerQ),
    .loopOnePowerQ(loopOnePowerQ), .clkSelOne(clkSelOne),
    .clkGateEn(clkGateEn), .sourceInUse(sourceInUse),
    .changeBusy(changeBusy), .coreResetQ(coreResetQ)
);

// >>> test_dpcs_clock_select.sv
// Self-checking bench for the dual-loop clock select block.
// Assumes the package, defines and checker are compiled first.
`include "dpcs_defs.svh"
`default_nettype none

module test_dpcs_clock_select;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hardResetInN = 1'b0;
    logic [4:0] extCfgPins = 5'h0a;
    logic [1:0] extRangePins = 2'h2;
    dpcs_pkg::dpcs_req_s busReq = '0;
    logic [31:0] rdataQ;
    dpcs_pkg::dpcs_loop_s loopZeroCfgQ;
    dpcs_pkg::dpcs_loop_s loopOneCfgQ;
    logic loopZeroPowerQ;
    logic loopOnePowerQ;
    logic clkSelOne;
    logic clkGateEn;
    logic sourceInUse;
    logic changeBusy;
    logic coreResetQ;
    int numErrors = 0;
    int totalChecks = 0;
    logic [31:0] d;

    // Short lock time: 100 ns is five bus cycles
    dpcs_clock_select #(.LOCK_NS(100)) u_dpcs_clock_select (
        .sys_clk(sys_clk), .arst_n(arst_n), .hardResetInN(hardResetInN),
        .extCfgPins(extCfgPins), .extRangePins(extRangePins),
        .busReq(busReq), .rdataQ(rdataQ), .loopZeroCfgQ(loopZeroCfgQ),
        .loopOneCfgQ(loopOneCfgQ), .loopZeroPowerQ(loopZeroPowerQ),
        .loopOnePowerQ(loopOnePowerQ), .clkSelOne(clkSelOne),
        .clkGateEn(clkGateEn), .sourceInUse(sourceInUse),
        .changeBusy(changeBusy), .coreResetQ(coreResetQ)
    );

    always #10 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        totalChecks++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen,
                exp);
        end
    endtask

    task automatic regWrite(input logic [3:0] a, input logic [31:0] w);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic regRead(input logic [3:0] a, output logic [31:0] r);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1 r = rdataQ;
    endtask

    function automatic logic [31:0] cfgWord(input logic ps, input logic pi0,
        input logic [4:0] pc0, input logic [1:0] pr0, input logic [4:0] pc1,
        input logic [1:0] pr1);
        return {8'h00, pr1, pc1, pr0, pc0, pi0, 1'b0, ps, 7'h00};
    endfunction

    task automatic waitLock(input int idx);
        logic [31:0] s;
        s = 32'h0000_0000;
        for (int n = 0; n < 30; n++)
        begin
            regRead(`DPCS_OFF_STAT, s);
            if (s[idx] === 1'b1)
                break;
        end
        check({31'h0, s[idx]}, 32'h1, "loop lock");
    endtask

    task automatic waitCore();
        repeat (40)
            if (coreResetQ !== 1'b0)
                @(posedge sys_clk);
        #1 check({31'h0, coreResetQ}, 32'h0, "core reset release");
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #200000;
        numErrors++;
        tallyAndFinish();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        regRead(`DPCS_OFF_CFG, d);
        check(d, 32'h0000_004a, "cfg under hard reset");
        regRead(`DPCS_OFF_STAT, d);
        check(d & 32'h8, 32'h8, "core reset status");
        @(posedge sys_clk);
        hardResetInN <= 1'b1;
        waitCore();
        check({25'h0, loopZeroCfgQ}, {25'h0, 5'h0a, 2'h2}, "strap");
        check({31'h0, clkSelOne}, 32'h0, "start on loop zero");
        check({25'h0, loopOneCfgQ}, 32'h0, "loop one off");
        check({31'h0, loopOnePowerQ}, 32'h0, "loop one unpowered");

        // The top multiplier code stops a loop just as code zero does
        regWrite(`DPCS_OFF_CFG, cfgWord(0, 0, 5'h00, 2'h0, 5'h1f, 2'h2));
        repeat (2) @(posedge sys_clk);
        #1 check({31'h0, loopOnePowerQ}, 32'h0, "off code");

        // Configure loop one, wait for lock, then select it
        regWrite(`DPCS_OFF_CFG,
            cfgWord(0, 0, 5'h00, 2'h0, 5'h0c, 2'h2));
        repeat (3) @(posedge sys_clk);
        #1 check({25'h0, loopOneCfgQ}, {25'h0, 5'h0c, 2'h2},
            "loop one");
        check({31'h0, loopOnePowerQ}, 32'h1, "loop one runs");
        waitLock(`DPCS_ST_LOCK1_BIT);
        regWrite(`DPCS_OFF_CFG, cfgWord(1, 0, 5'h00, 2'h0, 5'h0c, 2'h2));
        @(posedge sys_clk);
        #1 check({30'h0, clkGateEn, changeBusy}, 32'h1, "gate closed");
        repeat (2) @(posedge sys_clk);
        #1 check({28'h0, clkGateEn, changeBusy, clkSelOne, sourceInUse},
            32'hb, "switched to one");
        regRead(`DPCS_OFF_CFG, d);
        check(d, cfgWord(1, 0, 5'h00, 2'h0, 5'h0c, 2'h2) | 32'h0000_014a,
            "in-use bit set");
        check({31'h0, coreResetQ}, 32'h0, "state kept");

        // Turn loop zero off; read-only bits ignore the write
        regWrite(`DPCS_OFF_CFG, 32'hff00_017f
            | cfgWord(1, 1, 5'h00, 2'h0, 5'h0c, 2'h2));
        repeat (3) @(posedge sys_clk);
        #1 check({31'h0, loopZeroPowerQ}, 32'h0, "loop zero off");
        regRead(`DPCS_OFF_CFG, d);
        check(d, cfgWord(1, 1, 5'h00, 2'h0, 5'h0c, 2'h2) | 32'h0000_014a,
            "read-only bits");

        // Bring loop zero back, then return to it back to back
        regWrite(`DPCS_OFF_CFG,
            cfgWord(1, 1, 5'h08, 2'h0, 5'h0c, 2'h2));
        waitLock(`DPCS_ST_LOCK0_BIT);
        regWrite(`DPCS_OFF_CFG, cfgWord(0, 1, 5'h08, 2'h0, 5'h0c, 2'h2));
        regRead(`DPCS_OFF_STAT, d);
        check(d & 32'h4, 32'h4, "busy while changing");
        repeat (3) @(posedge sys_clk);
        #1 check({29'h0, clkGateEn, clkSelOne, sourceInUse}, 32'h4,
            "back on loop zero");
        check({25'h0, loopZeroCfgQ}, {25'h0, 5'h08, 2'h0}, "internal");

        // Unmapped address
        regWrite(4'h8, 32'hffff_ffff);
        regRead(4'h8, d);
        check(d, 32'h0000_0000, "unmapped read");

        // Hard reset with new pins
        @(posedge sys_clk);
        hardResetInN <= 1'b0;
        extCfgPins <= 5'h10;
        extRangePins <= 2'h0;
        repeat (10) @(posedge sys_clk);
        #1 check({29'h0, coreResetQ, clkSelOne, sourceInUse}, 32'h4,
            "hard reset state");
        check({25'h0, loopOneCfgQ}, 32'h0, "loop one cleared");
        regRead(`DPCS_OFF_CFG, d);
        check(d, 32'h0000_0010, "new strap");
        @(posedge sys_clk);
        hardResetInN <= 1'b1;
        waitCore();
        check({25'h0, loopZeroCfgQ}, {25'h0, 5'h10, 2'h0}, "relock");
        tallyAndFinish();
    end
endmodule

`default_nettype wire
